// >>> hw/casd_alu_half.sv
`timescale 1ns/10ps
`default_nettype none

module casd_alu_half (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire casd_pkg::casd_op_t op,
  // Result
  output logic [7:0] y,
  output logic carry_out,
  output logic sign_ovf
);

  logic [8:0] sum;

  // For subtraction carry_in and carry_out are borrows.
  always_comb begin
    sum = 9'h000;
    y = 8'h00;
    sign_ovf = 1'b0;
    case (op)
      casd_pkg::OP_ADD: begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
        y = sum[7:0];
        sign_ovf = (a[7] == b[7]) && (y[7] != a[7]);
      end
      casd_pkg::OP_SUB: begin
        sum = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
        y = sum[7:0];
        sign_ovf = (a[7] != b[7]) && (y[7] != a[7]);
      end
      casd_pkg::OP_AND: y = a & b;
      casd_pkg::OP_OR: y = a | b;
      casd_pkg::OP_XOR: y = a ^ b;
      casd_pkg::OP_INV: y = ~a;
      default: y = a;
    endcase
  end

  assign carry_out = sum[8];

endmodule

`default_nettype wire

// >>> hw/casd_datapath.sv
// Functional notes
// - Negate by inverting bits, then adding one.
// - Leftmost bit is sign; negatives two's complement.
// - Carries move up; borrows taken from above.
// - Word is even high byte, odd low byte.
// - Odd word address accesses address minus one.
// - Byte access touches only the addressed byte.
// - Unit adds, subtracts, ANDs, ORs, XORs, complements.
// - Separate comparator drives flag word bits 0-2.
// - Arithmetic built from two cooperating 8-bit halves.
// - Byte operands use upper half; lower ignored.
// - Pointer is 15-bit word address of next.
// - Fetch from pointer, then increment it.
// - Writing pointer redirects execution there.
// - Flag word is full 16-bit, feeds interrupts.
// - Flag bits assigned 0-6 and 10 as listed.
// - Spare bits 7, 8, 9, 11 store freely.
// - Flags testable, bit-updatable, loadable, interrupt-modified.
// - Bit 0 is most significant, 15 least.
`timescale 1ns/10ps
`default_nettype none

module casd_datapath (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Context switch load from the interrupt sequencer
  input wire logic ctx_load,
  input wire logic [15:0] ctx_flags,
  input wire logic [14:0] ctx_ip,
  // Interrupt priority side
  output logic range_trap_enable,
  output logic [3:0] int_mask_level,
  // Instruction fetch
  output logic [15:0] fetch_addr,
  output logic fetch_strobe,
  // Translated memory access
  output logic [15:0] mem_addr,
  output logic mem_hi_en,
  output logic mem_lo_en
);

  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic [15:0] opa_reg, opb_reg, cmd_reg, result_reg, result_next;
  logic [15:0] processor_flags_word_reg, flags_next;
  logic [14:0] instruction_pointer_reg;
  logic [15:0] fetch_addr_reg, mem_addr_reg;
  logic fetch_strobe_reg, mem_hi_en_reg, mem_lo_en_reg, mem_byte_reg;

  logic apb_wr, cmd_wr, rd_hit, cmd_byte;
  logic [31:0] rd_data;
  casd_pkg::casd_op_t cmd_op, half_op;
  logic [3:0] cmd_idx;
  logic [15:0] half_a, half_b, cmp_x, cmp_y, wdata16;
  logic lo_cin, hi_cin, lo_cout, hi_cout, hi_ovf;
  logic [7:0] lo_y, hi_y, opa_lo;

  // Bit n of the flag word sits at vector index 15 - n.
  function automatic logic [3:0] word_bit(input logic [3:0] n);
    word_bit = 4'hf - n;
  endfunction

  // Byte operands are left aligned so one comparator serves both sizes.
  function automatic logic [15:0] cmp_view(input logic [15:0] v,
                                           input logic byte_mode);
    cmp_view = byte_mode ? {v[15:8], 8'h00} : v;
  endfunction

  assign apb_wr = psel && penable && pready_reg && pwrite;
  assign cmd_wr = apb_wr && (paddr == casd_pkg::OFS_CMD);
  assign cmd_op = casd_pkg::casd_op_t'(pwdata[casd_pkg::CMD_OP_LSB +: 4]);
  assign cmd_byte = pwdata[casd_pkg::CMD_BYTE_BIT];
  assign cmd_idx = pwdata[casd_pkg::CMD_IDX_LSB +: 4];
  assign wdata16 = pwdata[15:0];
  assign opa_lo = opa_reg[7:0];

  // Operand steering into the two halves.
  always_comb begin
    half_op = cmd_op;
    half_a = opa_reg;
    half_b = opb_reg;
    lo_cin = 1'b0;
    if (cmd_op == casd_pkg::OP_NEG) begin
      half_op = casd_pkg::OP_ADD;
      half_a = ~opa_reg;
      half_b = casd_pkg::WORD_RST;
      lo_cin = 1'b1;
    end else if (cmd_op == casd_pkg::OP_CMP) begin
      half_op = casd_pkg::OP_SUB;
    end
  end

  // A byte operation cuts the chain, so the upper half stands alone.
  assign hi_cin = cmd_byte ? lo_cin : lo_cout;

  casd_alu_half u_lo_half (
    .a(half_a[7:0]),
    .b(half_b[7:0]),
    .carry_in(lo_cin),
    .op(half_op),
    .y(lo_y),
    .carry_out(lo_cout),
    .sign_ovf()
  );

  casd_alu_half u_hi_half (
    .a(half_a[15:8]),
    .b(half_b[15:8]),
    .carry_in(hi_cin),
    .op(half_op),
    .y(hi_y),
    .carry_out(hi_cout),
    .sign_ovf(hi_ovf)
  );

  // The lower half's answer is dropped for bytes; the other byte is kept.
  assign result_next = cmd_byte ? {hi_y, opa_reg[7:0]} : {hi_y, lo_y};

  // Comparator, separate from the halves.
  always_comb begin
    if (cmd_op == casd_pkg::OP_CMP) begin
      cmp_x = cmp_view(opa_reg, cmd_byte);
      cmp_y = cmp_view(opb_reg, cmd_byte);
    end else begin
      cmp_x = cmp_view(result_next, cmd_byte);
      cmp_y = casd_pkg::WORD_RST;
    end
  end

  // Next flag word for a command.
  always_comb begin
    flags_next = processor_flags_word_reg;
    if (cmd_op <= casd_pkg::OP_CMP) begin
      flags_next[casd_pkg::FB_LGT] = cmp_x > cmp_y;
      flags_next[casd_pkg::FB_AGT] = $signed(cmp_x) > $signed(cmp_y);
      flags_next[casd_pkg::FB_SAME] = cmp_x == cmp_y;
    end
    if (cmd_op == casd_pkg::OP_ADD || cmd_op == casd_pkg::OP_NEG) begin
      flags_next[casd_pkg::FB_C] = hi_cout;
      flags_next[casd_pkg::FB_RANGE] = hi_ovf;
    end else if (cmd_op == casd_pkg::OP_SUB) begin
      // Carry reads as no borrow out of the top.
      flags_next[casd_pkg::FB_C] = ~hi_cout;
      flags_next[casd_pkg::FB_RANGE] = hi_ovf;
    end
    if (cmd_byte && cmd_op < casd_pkg::OP_CMP) begin
      flags_next[casd_pkg::FB_PAR] = ^result_next[15:8];
    end
    if (cmd_op == casd_pkg::OP_SETB) begin
      flags_next[word_bit(cmd_idx)] = 1'b1;
    end else if (cmd_op == casd_pkg::OP_CLRB) begin
      flags_next[word_bit(cmd_idx)] = 1'b0;
    end
  end

  // Flag word. A context load takes priority over software.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      processor_flags_word_reg <= casd_pkg::FLAGS_RST;
    end else if (ctx_load) begin
      processor_flags_word_reg <= ctx_flags;
    end else if (apb_wr && paddr == casd_pkg::OFS_FLAGS) begin
      processor_flags_word_reg <= wdata16;
    end else if (cmd_wr) begin
      processor_flags_word_reg <= flags_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opa_reg <= casd_pkg::WORD_RST;
      opb_reg <= casd_pkg::WORD_RST;
      cmd_reg <= casd_pkg::WORD_RST;
      result_reg <= casd_pkg::WORD_RST;
    end else begin
      if (apb_wr && paddr == casd_pkg::OFS_OPA) begin
        opa_reg <= wdata16;
      end
      if (apb_wr && paddr == casd_pkg::OFS_OPB) begin
        opb_reg <= wdata16;
      end
      if (cmd_wr) begin
        cmd_reg <= wdata16;
      end
      if (cmd_wr && cmd_op < casd_pkg::OP_CMP) begin
        result_reg <= result_next;
      end
    end
  end

  // Instruction pointer and fetch.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      instruction_pointer_reg <= casd_pkg::IP_RST;
      fetch_addr_reg <= casd_pkg::WORD_RST;
      fetch_strobe_reg <= 1'b0;
    end else begin
      fetch_strobe_reg <= 1'b0;
      if (ctx_load) begin
        instruction_pointer_reg <= ctx_ip;
      end else if (apb_wr && paddr == casd_pkg::OFS_IP) begin
        instruction_pointer_reg <= pwdata[14:0];
      end else if (cmd_wr && cmd_op == casd_pkg::OP_STEP) begin
        instruction_pointer_reg <= instruction_pointer_reg + 15'h0001;
      end
      if (!ctx_load && cmd_wr && cmd_op == casd_pkg::OP_STEP) begin
        fetch_addr_reg <= {instruction_pointer_reg, 1'b0};
        fetch_strobe_reg <= 1'b1;
      end
    end
  end

  // Memory access translation.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_addr_reg <= casd_pkg::WORD_RST;
      mem_hi_en_reg <= 1'b0;
      mem_lo_en_reg <= 1'b0;
      mem_byte_reg <= 1'b0;
    end else if (apb_wr && paddr == casd_pkg::OFS_ACCESS) begin
      mem_byte_reg <= pwdata[casd_pkg::ACC_BYTE_BIT];
      if (pwdata[casd_pkg::ACC_BYTE_BIT]) begin
        mem_addr_reg <= wdata16;
        mem_hi_en_reg <= ~pwdata[0];
        mem_lo_en_reg <= pwdata[0];
      end else begin
        mem_addr_reg <= {pwdata[15:1], 1'b0};
        mem_hi_en_reg <= 1'b1;
        mem_lo_en_reg <= 1'b1;
      end
    end
  end

  // Read decode.
  always_comb begin
    rd_data = casd_pkg::PRDATA_RST;
    rd_hit = 1'b1;
    if (paddr == casd_pkg::OFS_OPA) begin
      rd_data[15:0] = opa_reg;
    end else if (paddr == casd_pkg::OFS_OPB) begin
      rd_data[15:0] = opb_reg;
    end else if (paddr == casd_pkg::OFS_CMD) begin
      rd_data[15:0] = cmd_reg;
    end else if (paddr == casd_pkg::OFS_RESULT) begin
      rd_data[15:0] = result_reg;
    end else if (paddr == casd_pkg::OFS_FLAGS) begin
      rd_data[15:0] = processor_flags_word_reg;
    end else if (paddr == casd_pkg::OFS_IP) begin
      rd_data[14:0] = instruction_pointer_reg;
    end else if (paddr == casd_pkg::OFS_FETCH) begin
      rd_data[15:0] = fetch_addr_reg;
    end else if (paddr == casd_pkg::OFS_ACCESS) begin
      rd_data[15:0] = mem_addr_reg;
      rd_data[casd_pkg::ACC_BYTE_BIT] = mem_byte_reg;
      rd_data[casd_pkg::ACC_LO_BIT] = mem_lo_en_reg;
      rd_data[casd_pkg::ACC_HI_BIT] = mem_hi_en_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Answer is raised at the setup edge, so every access ends after one
  // access cycle and read data never changes while it is being sampled.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= casd_pkg::PRDATA_RST;
    end else if (psel && !penable) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !rd_hit;
      prdata_reg <= pwrite ? casd_pkg::PRDATA_RST : rd_data;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign range_trap_enable =
    processor_flags_word_reg[casd_pkg::FB_TRAP_EN];
  assign int_mask_level =
    processor_flags_word_reg[casd_pkg::FB_MASK_LSB +: casd_pkg::MASK_W];
  assign fetch_addr = fetch_addr_reg;
  assign fetch_strobe = fetch_strobe_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_hi_en = mem_hi_en_reg;
  assign mem_lo_en = mem_lo_en_reg;

  a_neg_invert_add: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_wr && cmd_op == casd_pkg::OP_NEG && !cmd_byte
    |=> result_reg == ~$past(opa_reg) + 16'h0001)
    else $error("negation result wrong");

  a_byte_low_kept: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_wr && cmd_byte && cmd_op < casd_pkg::OP_CMP
    |=> result_reg[7:0] == $past(opa_lo))
    else $error("byte op disturbed low byte");

  a_add_word_carry: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_wr && cmd_op == casd_pkg::OP_ADD && !cmd_byte && !ctx_load
    |=> {processor_flags_word_reg[casd_pkg::FB_C], result_reg} ==
        {1'b0, $past(opa_reg)} + {1'b0, $past(opb_reg)})
    else $error("word add sum or carry wrong");

  a_cmp_equal_flag: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_wr && cmd_op == casd_pkg::OP_CMP && !cmd_byte && !ctx_load
    |=> processor_flags_word_reg[casd_pkg::FB_SAME] ==
        ($past(opa_reg) == $past(opb_reg)))
    else $error("compare equal flag wrong");

  a_cmp_signed_flag: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_wr && cmd_op == casd_pkg::OP_CMP && !cmd_byte && !ctx_load
    |=> processor_flags_word_reg[casd_pkg::FB_AGT] ==
        ($signed($past(opa_reg)) > $signed($past(opb_reg))))
    else $error("compare signed flag wrong");

  a_ip_step_fetch: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_wr && cmd_op == casd_pkg::OP_STEP && !ctx_load
    |=> instruction_pointer_reg == $past(instruction_pointer_reg) + 15'h0001
        && fetch_addr == {$past(instruction_pointer_reg), 1'b0}
        && fetch_strobe ##1 !fetch_strobe)
    else $error("pointer step or fetch wrong");

  a_flags_readback: assert property (@(posedge sys_clk) disable iff (reset)
    apb_wr && paddr == casd_pkg::OFS_FLAGS && !ctx_load
    |=> processor_flags_word_reg == $past(wdata16))
    else $error("flag word load lost bits");

  a_word_even_addr: assert property (@(posedge sys_clk) disable iff (reset)
    mem_hi_en && mem_lo_en |-> !mem_addr[0])
    else $error("word access at odd address");

  a_byte_one_lane: assert property (@(posedge sys_clk) disable iff (reset)
    mem_byte_reg |-> (mem_hi_en ^ mem_lo_en) && (mem_lo_en == mem_addr[0]))
    else $error("byte access enables wrong lane");

  a_apb_one_wait: assert property (@(posedge sys_clk) disable iff (reset)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule

`default_nettype wire

// >>> hw/casd_pkg.sv
package casd_pkg;

  // Datapath widths.
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IP_W = 15;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_OPA = 8'h00;
  localparam logic [7:0] OFS_OPB = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IP = 8'h14;
  localparam logic [7:0] OFS_FETCH = 8'h18;
  localparam logic [7:0] OFS_ACCESS = 8'h1c;

  // Reset values.
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [14:0] IP_RST = 15'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

  // Flag positions as vector indices; word bit n sits at index 15 - n.
  localparam int unsigned FB_LGT = 15;
  localparam int unsigned FB_AGT = 14;
  localparam int unsigned FB_SAME = 13;
  localparam int unsigned FB_C = 12;
  localparam int unsigned FB_RANGE = 11;
  localparam int unsigned FB_PAR = 10;
  localparam int unsigned FB_X = 9;
  localparam int unsigned FB_TRAP_EN = 5;
  localparam int unsigned FB_MASK_LSB = 0;
  localparam int unsigned MASK_W = 4;

  // Command word fields.
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_BYTE_BIT = 4;
  localparam int unsigned CMD_IDX_LSB = 8;

  // Access translation word fields.
  localparam int unsigned ACC_BYTE_BIT = 16;
  localparam int unsigned ACC_LO_BIT = 17;
  localparam int unsigned ACC_HI_BIT = 18;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_AND = 4'h2,
    OP_OR = 4'h3,
    OP_XOR = 4'h4,
    OP_INV = 4'h5,
    OP_NEG = 4'h6,
    OP_CMP = 4'h7,
    OP_STEP = 4'h8,
    OP_SETB = 4'h9,
    OP_CLRB = 4'ha
  } casd_op_t;

endpackage

// >>> sim/cpu_alu_status_datapath_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  errors++; $display("[FAIL] %0t got %h want %h", $time, got, exp); end end

module cpu_alu_status_datapath_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ctx_load = 1'b0;
  logic [15:0] ctx_flags = 16'h0000;
  logic [14:0] ctx_ip = 15'h0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, range_trap_enable, fetch_strobe;
  logic mem_hi_en, mem_lo_en, e;
  logic [3:0] int_mask_level;
  logic [15:0] fetch_addr, mem_addr;
  logic [18:0] acc [3] = '{19'h0_1235, 19'h1_1235, 19'h1_4000};
  logic [18:0] acc_exp [3] = '{19'h6_1234, 19'h3_1235, 19'h5_4000};
  int errors = 0;
  int tests_run = 0;
  int strobes = 0;

  always #4 sys_clk = ~sys_clk;

  casd_datapath u_dut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctx_load(ctx_load),
    .ctx_flags(ctx_flags), .ctx_ip(ctx_ip),
    .range_trap_enable(range_trap_enable),
    .int_mask_level(int_mask_level), .fetch_addr(fetch_addr),
    .fetch_strobe(fetch_strobe), .mem_addr(mem_addr),
    .mem_hi_en(mem_hi_en), .mem_lo_en(mem_lo_en)
  );

  // Registered outputs are looked at mid-cycle so no edge race can occur.
  always @(negedge sys_clk) begin
    if (fetch_strobe === 1'b1) strobes++;
  end

  task report_and_stop;
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // The answer is taken at the rising edge where pready is seen high, and
  // only then is the request released, so it always lasts through that edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (pready !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t no bus answer", $time);
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(e, 1'b0)
    `CHK(q, x)
  endtask

  task op(input logic [3:0] c, input logic bm, input logic [3:0] idx);
    wr(casd_pkg::OFS_CMD, {20'h00000, idx, 3'h0, bm, c});
  endtask

  task alu(input logic [3:0] c, input logic bm, input logic [15:0] a,
           input logic [15:0] b, input logic [15:0] pre,
           input logic [15:0] res, input logic [15:0] f,
           input logic [15:0] m);
    wr(casd_pkg::OFS_FLAGS, {16'h0000, pre});
    wr(casd_pkg::OFS_OPA, {16'h0000, a});
    wr(casd_pkg::OFS_OPB, {16'h0000, b});
    op(c, bm, 4'h0);
    rd(casd_pkg::OFS_RESULT, {16'h0000, res});
    apb(1'b0, casd_pkg::OFS_FLAGS, 32'h0000_0000);
    `CHK(q[15:0] & m, f)
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    `CHK({fetch_strobe, mem_hi_en, mem_lo_en, int_mask_level}, 7'h00)
    rd(casd_pkg::OFS_FLAGS, 32'h0000_0000);
    rd(casd_pkg::OFS_IP, 32'h0000_0000);
    alu(casd_pkg::OP_ADD, 0, 16'h7fff, 16'h0001, 0, 16'h8000, 16'h8800,
        16'hf800);
    alu(casd_pkg::OP_SUB, 0, 16'h0005, 16'h0005, 0, 0, 16'h3000,
        16'hf800);
    alu(casd_pkg::OP_SUB, 0, 16'h0000, 16'h0001, 0, 16'hffff, 16'h8000,
        16'hf800);
    alu(casd_pkg::OP_SUB, 0, 16'h8000, 16'h0001, 0, 16'h7fff, 16'hd800,
        16'hf800);
    alu(casd_pkg::OP_NEG, 0, 16'h39f6, 0, 0, 16'hc60a, 16'h8000,
        16'he000);
    alu(casd_pkg::OP_NEG, 0, 16'hc60a, 0, 0, 16'h39f6, 16'hc000,
        16'he000);
    alu(casd_pkg::OP_AND, 0, 16'hf0f0, 16'hff00, 16'h1800, 16'hf000,
        16'h9800, 16'hffff);
    alu(casd_pkg::OP_OR, 0, 16'hf0f0, 16'hff00, 16'h1800, 16'hfff0,
        16'h9800, 16'hffff);
    alu(casd_pkg::OP_XOR, 0, 16'hf0f0, 16'hff00, 16'h1800, 16'h0ff0,
        16'hd800, 16'hffff);
    alu(casd_pkg::OP_INV, 0, 16'hf0f0, 16'hff00, 16'h1800, 16'h0f0f,
        16'hd800, 16'hffff);
    alu(casd_pkg::OP_CMP, 0, 16'h8000, 16'h0001, 0, 16'h0f0f, 16'h8000,
        16'he000);
    alu(casd_pkg::OP_CMP, 0, 16'h0001, 16'hffff, 0, 16'h0f0f, 16'h4000,
        16'he000);
    alu(casd_pkg::OP_CMP, 0, 16'h1234, 16'h1234, 0, 16'h0f0f, 16'h2000,
        16'he000);
    alu(casd_pkg::OP_ADD, 1, 16'h7f12, 16'h0134, 0, 16'h8012, 16'h8c00,
        16'hfc00);
    alu(casd_pkg::OP_ADD, 1, 16'hff12, 16'h01ff, 0, 16'h0012, 16'h3000,
        16'hfc00);
    alu(casd_pkg::OP_XOR, 1, 16'h0f55, 16'h01aa, 0, 16'h0e55, 16'hc400,
        16'hfc00);
    wr(casd_pkg::OFS_RESULT, 32'h0000_ffff);
    rd(casd_pkg::OFS_RESULT, 32'h0000_0e55);
    wr(casd_pkg::OFS_FLAGS, 32'h0000_5a5a);
    rd(casd_pkg::OFS_FLAGS, 32'h0000_5a5a);
    `CHK({range_trap_enable, int_mask_level}, 5'h0a)
    wr(casd_pkg::OFS_FLAGS, 32'h0000_0025);
    @(negedge sys_clk);
    `CHK({range_trap_enable, int_mask_level}, 5'h15)
    wr(casd_pkg::OFS_FLAGS, 32'h0000_0000);
    op(casd_pkg::OP_SETB, 0, 4'h7);
    op(casd_pkg::OP_SETB, 0, 4'hb);
    rd(casd_pkg::OFS_FLAGS, 32'h0000_0110);
    op(casd_pkg::OP_CLRB, 0, 4'h7);
    rd(casd_pkg::OFS_FLAGS, 32'h0000_0010);
    wr(casd_pkg::OFS_IP, 32'h0000_1234);
    op(casd_pkg::OP_STEP, 0, 4'h0);
    rd(casd_pkg::OFS_IP, 32'h0000_1235);
    rd(casd_pkg::OFS_FETCH, 32'h0000_2468);
    `CHK(fetch_addr, 16'h2468)
    wr(casd_pkg::OFS_IP, 32'h0000_7fff);
    op(casd_pkg::OP_STEP, 0, 4'h0);
    rd(casd_pkg::OFS_IP, 32'h0000_0000);
    rd(casd_pkg::OFS_FETCH, 32'h0000_fffe);
    `CHK(strobes, 2)
    for (int i = 0; i < 3; i++) begin
      wr(casd_pkg::OFS_ACCESS, {13'h0000, acc[i]});
      rd(casd_pkg::OFS_ACCESS, {13'h0000, acc_exp[i]});
      `CHK({mem_hi_en, mem_lo_en, mem_addr},
           {acc_exp[i][18:17], acc_exp[i][15:0]})
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK({e, q}, 33'h1_0000_0000)
    apb(1'b1, 8'h40, 32'h0000_1111);
    `CHK(e, 1'b1)
    @(posedge sys_clk);
    ctx_flags <= 16'habcd;
    ctx_ip <= 15'h0321;
    ctx_load <= 1'b1;
    wr(casd_pkg::OFS_FLAGS, 32'h0000_1111);
    ctx_load <= 1'b0;
    rd(casd_pkg::OFS_FLAGS, 32'h0000_abcd);
    rd(casd_pkg::OFS_IP, 32'h0000_0321);
    `CHK(int_mask_level, 4'hd)
    report_and_stop();
  end
endmodule

`undef CHK
`default_nettype wire
